// file: logic/rcr_pkg.sv
package rcr_pkg;
	// ****************************************
	// sizes
	// ****************************************
	localparam int NUM_PORTS = 13;
	localparam int PORT_W = 4;
	localparam int CNT_W = 16;
	localparam int AW = 8;
	localparam int DW = 32;
	localparam logic [PORT_W-1:0] PORT_BASE = 4'h1;

	// ****************************************
	// register map (index, byte address = index * 4)
	// ****************************************
	localparam logic [AW-1:0] IDX_CFG = 8'h0e;
	localparam logic [AW-1:0] IDX_VEC = 8'h0f;
	localparam logic [AW-1:0] IDX_PAGE = 8'h10;
	localparam logic [AW-1:0] ADDR_CFG = 8'(IDX_CFG * 4);
	localparam logic [AW-1:0] ADDR_VEC = 8'(IDX_VEC * 4);
	localparam logic [AW-1:0] ADDR_PAGE = 8'(IDX_PAGE * 4);

	// ****************************************
	// configuration bits and decoded values
	// ****************************************
	localparam int CFG_GLOBAL_SECURITY = 0;
	localparam int CFG_RECOVERY = 1;
	localparam int CFG_COL_LIMIT = 2;
	localparam int CFG_LOOPBACK_PART = 3;
	localparam int CFG_LATE_COL = 4;
	localparam int CFG_RECONNECT_TX = 5;
	localparam int CFG_PART_ALLOW = 6;
	localparam int CFG_LED_MODE = 7;
	localparam logic [7:0] CFG_RESET = 8'h00;
	localparam logic [2:0] RECOVERY_LONG = 3'h5;
	localparam logic [2:0] RECOVERY_SHORT = 3'h3;
	localparam logic [5:0] COL_LIMIT_HI = 6'h3f;
	localparam logic [5:0] COL_LIMIT_LO = 6'h1f;

	// ****************************************
	// interrupt vector codes and page fields
	// ****************************************
	localparam logic [3:0] SRC_CODE_SA = 4'he;
	localparam logic [3:0] SRC_CODE_COL = 4'hd;
	localparam logic [3:0] SRC_CODE_RX = 4'hb;
	localparam logic [3:0] SRC_CODE_PART = 4'h7;
	localparam logic [7:0] VEC_NONE = 8'hff;
	localparam int PAGE_W = 4;
	localparam logic [PAGE_W-1:0] PAGE_RESET = 4'h0;
	localparam int SUM_FLAG_FOUND = 4;
	localparam int SUM_LOW_COUNT = 5;
	localparam int SUM_HIGH_COUNT = 6;
	localparam int SUM_FULL_COUNT = 7;
	localparam logic [CNT_W-1:0] CNT_LOW = 16'h00ff;
	localparam logic [CNT_W-1:0] CNT_HIGH = 16'hc000;
	localparam logic [CNT_W-1:0] CNT_FULL = 16'hffff;

	// ****************************************
	// types
	// ****************************************
	typedef enum logic [2:0] {SRC_NONE, SRC_SA, SRC_RX, SRC_COL, SRC_PART} rcr_src_type;

	typedef struct packed {
		logic sa_valid;
		logic [PORT_W-1:0] sa_port;
		logic rx_valid;
		logic [PORT_W-1:0] rx_port;
		logic col_valid;
		logic [PORT_W-1:0] col_port;
		logic [NUM_PORTS-1:0] part_vec;
	} rcr_evt_type;

	typedef struct packed {
		logic security_mode;
		logic [2:0] recovery_bits;
		logic [5:0] collision_limit;
		logic loopback_part_en;
		logic late_col_as_late;
		logic reconnect_any_packet;
		logic auto_partition_en;
		logic led_max_mode;
	} rcr_cfg_type;
endpackage

// file: logic/rcr_regs.sv
// Register access over APB was chosen for this implementation.
`timescale 1ns/100ps
// What this block does
// - expose mode-load captured options read-only, one option per bit
// - option bit 0 low means security with learning; high means no security
// - bit 1 selects carrier recovery of 5 bits (0) or 3 bits (1)
// - bit 2 selects collision partition limit 63 (0) or 31 (1)
// - bit 3 low enables loopback-failure partition; high suppresses it
// - bit 4 low treats late collisions as in-window; high as late
// - bit 5 low reconnects only on own transmit; high on any packet
// - bit 6 low blocks automatic partitioning; high permits it
// - bit 7 selects minimum (0) or maximum (1) LED display
// - start of next packet transmission discards unread interrupts
// - secure priority: address mismatch, receive, first collision, partition
// - partition/reconnect ports share priority, served by rotating poll
// - reading the interrupt vector clears the returned event; empty gives none code
// - vector holds source code in bits 3..0, port number in bits 7..4
// - source code is active-low one-hot per source
// - nothing pending reads as all ones
// - processor writes 4-bit page; device returns current page on reads
// - flag_found set when any unmasked record latch is set
// - low_count set when any counter is below 00ff
// - high_count set when any counter is above c000
// - full_count set when any counter equals ffff
// - page register decodes at one address on every page
module rcr_regs
	import rcr_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic clk_en,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [rcr_pkg::AW-1:0] paddr,
	input wire logic [rcr_pkg::DW-1:0] pwdata,
	output logic [rcr_pkg::DW-1:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic mode_load_strobe,
	input wire logic [7:0] mode_load_data,
	input wire logic tx_start,
	input wire rcr_pkg::rcr_evt_type evt,
	input wire logic [rcr_pkg::NUM_PORTS-1:0] record_latch_set,
	input wire logic [rcr_pkg::NUM_PORTS-1:0][rcr_pkg::CNT_W-1:0] port_counts,
	output rcr_pkg::rcr_cfg_type cfg_out,
	output logic [rcr_pkg::PAGE_W-1:0] upper_page
);
	import rcr_pkg::*;

	// ****************************************
	// helpers
	// ****************************************
	function automatic logic [PORT_W-1:0] pick_part(input logic [NUM_PORTS-1:0] vec,
		input logic [PORT_W-1:0] start);
		logic [PORT_W-1:0] idx;
		logic found;
		logic [PORT_W:0] k;
		idx = start;
		found = 1'b0;
		for (int i = 0; i < NUM_PORTS; i++) begin
			k = 5'(start) + 5'(i);
			if (k >= 5'(NUM_PORTS)) begin
				k = k - 5'(NUM_PORTS);
			end
			if (!found && vec[k[PORT_W-1:0]]) begin
				idx = k[PORT_W-1:0];
				found = 1'b1;
			end
		end
		return idx;
	endfunction

	function automatic logic [PORT_W-1:0] wrap_next(input logic [PORT_W-1:0] idx);
		return (idx == PORT_W'(NUM_PORTS - 1)) ? '0 : PORT_W'(idx + 1'b1);
	endfunction

	function automatic logic [7:0] vec_word(input rcr_src_type src,
		input logic [PORT_W-1:0] port);
		case (src)
			SRC_SA: vec_word = {port, SRC_CODE_SA};
			SRC_RX: vec_word = {port, SRC_CODE_RX};
			SRC_COL: vec_word = {port, SRC_CODE_COL};
			SRC_PART: vec_word = {port, SRC_CODE_PART};
			default: vec_word = VEC_NONE;
		endcase
	endfunction

	// ****************************************
	// apb handshake
	// ****************************************
	logic loaded_r;
	logic [DW-1:0] prdata_r;
	logic pslverr_r;
	logic setup_go;
	logic rd_done;
	logic wr_done;
	logic hit_cfg;
	logic hit_vec;
	logic hit_page;

	assign hit_cfg = (paddr == ADDR_CFG);
	assign hit_vec = (paddr == ADDR_VEC);
	assign hit_page = (paddr == ADDR_PAGE);
	assign setup_go = clk_en && psel && !loaded_r;
	assign pready = psel && penable && loaded_r && clk_en;
	assign rd_done = pready && !pwrite;
	assign wr_done = pready && pwrite;
	assign prdata = prdata_r;
	assign pslverr = pslverr_r && pready;

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			loaded_r <= 1'b0;
		end else if (clk_en) begin
			loaded_r <= psel && !pready;
		end
	end

	// ****************************************
	// mode-load configuration
	// ****************************************
	logic [7:0] cfg_r;
	rcr_cfg_type cfg_out_r;
	logic secure;

	assign secure = !cfg_r[CFG_GLOBAL_SECURITY];
	assign cfg_out = cfg_out_r;

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			cfg_r <= CFG_RESET;
		end else if (clk_en && mode_load_strobe) begin
			cfg_r <= mode_load_data;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			cfg_out_r <= '0;
		end else if (clk_en) begin
			cfg_out_r.security_mode <= !cfg_r[CFG_GLOBAL_SECURITY];
			cfg_out_r.recovery_bits <= cfg_r[CFG_RECOVERY] ? RECOVERY_SHORT : RECOVERY_LONG;
			cfg_out_r.collision_limit <= cfg_r[CFG_COL_LIMIT] ? COL_LIMIT_LO : COL_LIMIT_HI;
			cfg_out_r.loopback_part_en <= !cfg_r[CFG_LOOPBACK_PART];
			cfg_out_r.late_col_as_late <= cfg_r[CFG_LATE_COL];
			cfg_out_r.reconnect_any_packet <= cfg_r[CFG_RECONNECT_TX];
			cfg_out_r.auto_partition_en <= cfg_r[CFG_PART_ALLOW];
			cfg_out_r.led_max_mode <= cfg_r[CFG_LED_MODE];
		end
	end

	// ****************************************
	// real-time interrupt pending events
	// ****************************************
	logic sa_pend_r;
	logic [PORT_W-1:0] sa_port_r;
	logic rx_pend_r;
	logic [PORT_W-1:0] rx_port_r;
	logic col_pend_r;
	logic col_seen_r;
	logic [PORT_W-1:0] col_port_r;
	logic [NUM_PORTS-1:0] part_pend_r;
	logic [NUM_PORTS-1:0] part_pend_nxt;
	logic [PORT_W-1:0] poll_r;
	rcr_src_type sel_src;
	rcr_src_type rd_src_r;
	logic [PORT_W-1:0] sel_idx;
	logic [PORT_W-1:0] sel_port;
	logic [PORT_W-1:0] rd_idx_r;
	logic vec_clear;

	assign vec_clear = rd_done && hit_vec;
	assign sel_idx = pick_part(part_pend_r, poll_r);

	always_comb begin
		sel_src = SRC_NONE;
		sel_port = '1;
		if (secure && sa_pend_r) begin
			sel_src = SRC_SA;
			sel_port = sa_port_r;
		end else if (rx_pend_r) begin
			sel_src = SRC_RX;
			sel_port = rx_port_r;
		end else if (col_pend_r) begin
			sel_src = SRC_COL;
			sel_port = col_port_r;
		end else if (|part_pend_r) begin
			sel_src = SRC_PART;
			sel_port = PORT_W'(sel_idx + PORT_BASE);
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			sa_pend_r <= 1'b0;
			sa_port_r <= '0;
		end else if (clk_en) begin
			if (evt.sa_valid && secure) begin
				sa_pend_r <= 1'b1;
				sa_port_r <= evt.sa_port;
			end else if (tx_start || (vec_clear && rd_src_r == SRC_SA)) begin
				sa_pend_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			rx_pend_r <= 1'b0;
			rx_port_r <= '0;
		end else if (clk_en) begin
			if (evt.rx_valid) begin
				rx_pend_r <= 1'b1;
				rx_port_r <= evt.rx_port;
			end else if (tx_start || (vec_clear && rd_src_r == SRC_RX)) begin
				rx_pend_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			col_pend_r <= 1'b0;
			col_seen_r <= 1'b0;
			col_port_r <= '0;
		end else if (clk_en) begin
			if (evt.col_valid && !col_seen_r) begin
				col_pend_r <= 1'b1;
				col_seen_r <= 1'b1;
				col_port_r <= evt.col_port;
			end else if (tx_start) begin
				col_pend_r <= 1'b0;
				col_seen_r <= 1'b0;
			end else if (vec_clear && rd_src_r == SRC_COL) begin
				col_pend_r <= 1'b0;
			end
		end
	end

	always_comb begin
		part_pend_nxt = part_pend_r;
		if (tx_start) begin
			part_pend_nxt = '0;
		end else if (vec_clear && rd_src_r == SRC_PART) begin
			part_pend_nxt[rd_idx_r] = 1'b0;
		end
		part_pend_nxt = part_pend_nxt | evt.part_vec;
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			part_pend_r <= '0;
			poll_r <= '0;
		end else if (clk_en) begin
			part_pend_r <= part_pend_nxt;
			if (vec_clear && rd_src_r == SRC_PART) begin
				poll_r <= wrap_next(rd_idx_r);
			end
		end
	end

	// ****************************************
	// page select and event summary
	// ****************************************
	logic [PAGE_W-1:0] page_r;
	logic [3:0] summary;

	assign upper_page = page_r;

	always_comb begin
		summary = '0;
		summary[SUM_FLAG_FOUND-SUM_FLAG_FOUND] = |record_latch_set;
		for (int i = 0; i < NUM_PORTS; i++) begin
			summary[SUM_LOW_COUNT-SUM_FLAG_FOUND] |= (port_counts[i] < CNT_LOW);
			summary[SUM_HIGH_COUNT-SUM_FLAG_FOUND] |= (port_counts[i] > CNT_HIGH);
			summary[SUM_FULL_COUNT-SUM_FLAG_FOUND] |= (port_counts[i] == CNT_FULL);
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			page_r <= PAGE_RESET;
		end else if (clk_en && wr_done && hit_page) begin
			page_r <= pwdata[PAGE_W-1:0];
		end
	end

	// ****************************************
	// read data capture
	// ****************************************
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			prdata_r <= '0;
			pslverr_r <= 1'b0;
			rd_src_r <= SRC_NONE;
			rd_idx_r <= '0;
		end else if (setup_go) begin
			prdata_r <= '0;
			pslverr_r <= !(hit_cfg || hit_vec || hit_page);
			rd_src_r <= SRC_NONE;
			rd_idx_r <= sel_idx;
			if (!pwrite && hit_cfg) begin
				prdata_r[7:0] <= cfg_r;
			end
			if (!pwrite && hit_vec) begin
				prdata_r[7:0] <= vec_word(sel_src, sel_port);
				rd_src_r <= sel_src;
			end
			if (!pwrite && hit_page) begin
				prdata_r[7:0] <= {summary, page_r};
			end
		end
	end

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_b);

	sequence vec_setup;
		setup_go && !pwrite && hit_vec;
	endsequence

	sequence page_setup;
		setup_go && !pwrite && hit_page;
	endsequence

	a_vec_none_code: assert property (vec_setup ##0 sel_src == SRC_NONE
		|=> prdata_r[7:0] == VEC_NONE)
		else $error("empty vector not all ones");
	a_vec_onehot_code: assert property (vec_setup ##0 sel_src != SRC_NONE
		|=> $countones(prdata_r[3:0]) == 3 && prdata_r[7:4] == $past(sel_port))
		else $error("vector code or port wrong");
	a_vec_read_clear: assert property (vec_clear && rd_src_r == SRC_RX && !evt.rx_valid
		|=> !rx_pend_r)
		else $error("read did not clear receive event");
	a_tx_discard_all: assert property (clk_en && tx_start && !evt.sa_valid && !evt.rx_valid
		&& !evt.col_valid && evt.part_vec == '0 |=> !sa_pend_r && !rx_pend_r && !col_pend_r
		&& part_pend_r == '0)
		else $error("pending event survived transmit start");
	a_sa_priority: assert property (secure && sa_pend_r |-> sel_src == SRC_SA)
		else $error("address mismatch not first");
	a_rx_priority: assert property (!(secure && sa_pend_r) && rx_pend_r
		|-> sel_src == SRC_RX)
		else $error("receive not second");
	a_col_priority: assert property (!(secure && sa_pend_r) && !rx_pend_r && col_pend_r
		|-> sel_src == SRC_COL)
		else $error("collision not third");
	a_part_rotate: assert property (vec_clear && rd_src_r == SRC_PART
		|=> poll_r == wrap_next($past(rd_idx_r)))
		else $error("partition poll did not advance");
	a_page_write: assert property (wr_done && hit_page
		|=> upper_page == $past(pwdata[PAGE_W-1:0]))
		else $error("page not stored");
	a_page_readback: assert property (page_setup
		|=> prdata_r[PAGE_W-1:0] == $past(page_r))
		else $error("page not returned");
	a_full_summary: assert property (page_setup ##0 (port_counts[0] == CNT_FULL)
		|=> prdata_r[SUM_FULL_COUNT])
		else $error("full count flag missing");
	a_cfg_capture: assert property (clk_en && mode_load_strobe
		|=> cfg_r == $past(mode_load_data))
		else $error("configuration capture wrong");
	a_cfg_decode: assert property (rst_b && clk_en
		|=> cfg_out_r.collision_limit == ($past(cfg_r[CFG_COL_LIMIT]) ? COL_LIMIT_LO : COL_LIMIT_HI)
		&& cfg_out_r.recovery_bits == ($past(cfg_r[CFG_RECOVERY]) ? RECOVERY_SHORT : RECOVERY_LONG))
		else $error("configuration decode wrong");
	a_ro_write: assert property (wr_done && (hit_cfg || hit_vec) && !mode_load_strobe
		|=> $stable(cfg_r))
		else $error("write changed read-only state");
	a_err_unmapped: assert property (pready |-> pslverr == !(hit_cfg || hit_vec || hit_page))
		else $error("error response wrong");
	a_freeze_hold: assert property (!clk_en |=> $stable(page_r) && $stable(cfg_r)
		&& $stable(part_pend_r))
		else $error("state moved while frozen");
endmodule

// file: bench/rcr_apb_master.sv
`timescale 1ns/100ps
// ****************************************
// processor port master
// ****************************************
module rcr_apb_master
	import rcr_pkg::*;
(
	input wire logic clk_sys,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [rcr_pkg::AW-1:0] paddr,
	output logic [rcr_pkg::DW-1:0] pwdata,
	input wire logic [rcr_pkg::DW-1:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
	end

	// one transfer, held until pready or until 64 further cycles pass without it
	task automatic xfer(input logic wr, input logic [AW-1:0] a, input logic [DW-1:0] wd,
		output logic [DW-1:0] rd, output logic err, output logic ok);
		int n;
		@(posedge clk_sys);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk_sys);
		penable <= 1'b1;
		n = 0;
		@(posedge clk_sys);
		while (pready !== 1'b1 && n < 64) begin
			@(posedge clk_sys);
			n++;
		end
		ok = (pready === 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// released lines show no stale value
		paddr <= ~a;
		pwdata <= ~wd;
	endtask
endmodule

// file: bench/rcr_regs_tb_top.sv
`timescale 1ns/100ps
module rcr_regs_tb_top;
	import rcr_pkg::*;
	logic clk_sys, rst_b, clk_en, psel, penable, pwrite, pready, pslverr;
	logic [AW-1:0] paddr;
	logic [DW-1:0] pwdata, prdata;
	logic mode_load_strobe, tx_start;
	logic [7:0] mode_load_data;
	rcr_evt_type evt;
	logic [NUM_PORTS-1:0] record_latch_set;
	logic [NUM_PORTS-1:0][CNT_W-1:0] port_counts;
	rcr_cfg_type cfg_out;
	logic [PAGE_W-1:0] upper_page;
	int error_cnt = 0;
	int compares = 0;

	rcr_regs dut (.clk_sys(clk_sys), .rst_b(rst_b), .clk_en(clk_en), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .mode_load_strobe(mode_load_strobe),
		.mode_load_data(mode_load_data), .tx_start(tx_start), .evt(evt),
		.record_latch_set(record_latch_set), .port_counts(port_counts), .cfg_out(cfg_out),
		.upper_page(upper_page));
	rcr_apb_master u_mst (.clk_sys(clk_sys), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

	// ****************************************
	// helpers
	// ****************************************
	task automatic complete_run();
		$display("mismatches %0d compares %0d", error_cnt, compares);
		if (error_cnt == 0 && compares > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [DW-1:0] got, input logic [DW-1:0] exp, input string m);
		compares++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
		end
	endtask

	task automatic bus(input logic wr, input logic [AW-1:0] a, input logic [DW-1:0] wd,
		output logic [DW-1:0] rd, output logic err);
		logic ok;
		u_mst.xfer(wr, a, wd, rd, err, ok);
		if (!ok) begin
			error_cnt++;
			$display("wrong value at %0t: no pready", $time);
			complete_run();
		end
	endtask

	task automatic rd_chk(input logic [AW-1:0] a, input logic [7:0] exp, input string m);
		logic [DW-1:0] d;
		logic e;
		bus(1'b0, a, '0, d, e);
		chk(d, {24'h0, exp}, m);
	endtask

	task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] wd);
		logic [DW-1:0] d;
		logic e;
		bus(1'b1, a, wd, d, e);
	endtask

	task automatic load_cfg(input logic [7:0] v);
		@(posedge clk_sys);
		mode_load_data <= v;
		mode_load_strobe <= 1'b1;
		@(posedge clk_sys);
		mode_load_strobe <= 1'b0;
		repeat (3) @(posedge clk_sys);
	endtask

	task automatic pulse_evt(input rcr_evt_type e, input logic tx);
		@(posedge clk_sys);
		evt <= e;
		tx_start <= tx;
		@(posedge clk_sys);
		evt <= '0;
		tx_start <= 1'b0;
	endtask

	function automatic rcr_cfg_type exp_cfg(input logic [7:0] v);
		rcr_cfg_type c;
		c.security_mode = ~v[0];
		c.recovery_bits = v[1] ? RECOVERY_SHORT : RECOVERY_LONG;
		c.collision_limit = v[2] ? COL_LIMIT_LO : COL_LIMIT_HI;
		c.loopback_part_en = ~v[3];
		c.late_col_as_late = v[4];
		c.reconnect_any_packet = v[5];
		c.auto_partition_en = v[6];
		c.led_max_mode = v[7];
		return c;
	endfunction

	// ****************************************
	// scenarios
	// ****************************************
	task automatic test_cfg();
		logic [7:0] vals[2] = '{8'ha5, 8'h5a};
		foreach (vals[i]) begin
			load_cfg(vals[i]);
			rd_chk(ADDR_CFG, vals[i], "cfg read");
			chk(DW'(cfg_out), DW'(exp_cfg(vals[i])), "cfg decode");
			wr(ADDR_CFG, 32'h0000_00ff);
			rd_chk(ADDR_CFG, vals[i], "cfg after write");
		end
		$display("test cfg done");
	endtask

	task automatic test_prio();
		rcr_evt_type e;
		load_cfg(8'h00);
		e = '0;
		e.sa_valid = 1'b1;
		e.sa_port = 4'h3;
		e.rx_valid = 1'b1;
		e.rx_port = 4'h5;
		e.col_valid = 1'b1;
		e.col_port = 4'h7;
		e.part_vec[8] = 1'b1;
		pulse_evt(e, 1'b0);
		wr(ADDR_VEC, 32'h0);
		rd_chk(ADDR_VEC, {4'h3, SRC_CODE_SA}, "sa first");
		rd_chk(ADDR_VEC, {4'h5, SRC_CODE_RX}, "rx second");
		rd_chk(ADDR_VEC, {4'h7, SRC_CODE_COL}, "col third");
		rd_chk(ADDR_VEC, {4'h9, SRC_CODE_PART}, "part last");
		rd_chk(ADDR_VEC, VEC_NONE, "empty");
		$display("test prio done");
	endtask

	task automatic test_poll();
		rcr_evt_type e;
		logic [DW-1:0] d1, d2;
		logic er;
		logic [7:0] a, b;
		e = '0;
		e.part_vec[1] = 1'b1;
		e.part_vec[3] = 1'b1;
		pulse_evt(e, 1'b0);
		bus(1'b0, ADDR_VEC, '0, d1, er);
		bus(1'b0, ADDR_VEC, '0, d2, er);
		a = {4'h2, SRC_CODE_PART};
		b = {4'h4, SRC_CODE_PART};
		chk(d1, DW'(a), "poll first");
		chk(d2, DW'(b), "poll second");
		rd_chk(ADDR_VEC, VEC_NONE, "poll empty");
		$display("test poll done");
	endtask

	task automatic test_tx();
		rcr_evt_type e;
		e = '0;
		e.rx_valid = 1'b1;
		e.rx_port = 4'h6;
		pulse_evt(e, 1'b0);
		pulse_evt('0, 1'b1);
		rd_chk(ADDR_VEC, VEC_NONE, "discard on tx");
		load_cfg(8'h01);
		e = '0;
		e.sa_valid = 1'b1;
		e.sa_port = 4'h2;
		pulse_evt(e, 1'b0);
		rd_chk(ADDR_VEC, VEC_NONE, "no sa when open");
		$display("test tx done");
	endtask

	task automatic test_stall();
		rcr_evt_type e;
		logic [DW-1:0] d;
		logic er, ok;
		e = '0;
		e.rx_valid = 1'b1;
		e.rx_port = 4'ha;
		pulse_evt(e, 1'b0);
		fork
			u_mst.xfer(1'b0, ADDR_VEC, '0, d, er, ok);
			begin
				@(posedge clk_sys);
				clk_en <= 1'b0;
				repeat (3) @(posedge clk_sys);
				clk_en <= 1'b1;
			end
		join
		chk(DW'(ok), 32'h1, "stall ready");
		chk(d, {24'h0, 4'ha, SRC_CODE_RX}, "stalled read");
		rd_chk(ADDR_VEC, VEC_NONE, "stall cleared");
		$display("test stall done");
	endtask

	task automatic test_page();
		logic [CNT_W-1:0] cv[6] = '{16'h1000, 16'h00fe, 16'h00ff, 16'hc000, 16'hc001, 16'hffff};
		logic [3:0] fx[6] = '{4'h1, 4'h2, 4'h0, 4'h0, 4'h4, 4'hc};
		logic [NUM_PORTS-1:0][CNT_W-1:0] pc;
		logic [DW-1:0] d;
		logic er;
		wr(ADDR_PAGE, 32'h0000_00f6);
		@(posedge clk_sys);
		chk(DW'(upper_page), 32'h6, "page out");
		foreach (cv[i]) begin
			pc = {NUM_PORTS{16'h1000}};
			pc[4] = cv[i];
			pc[0] = cv[i];
			@(posedge clk_sys);
			port_counts <= pc;
			record_latch_set <= (i == 0) ? 13'h0100 : 13'h0;
			rd_chk(ADDR_PAGE, {fx[i], 4'h6}, "summary");
		end
		bus(1'b0, 8'h44, '0, d, er);
		chk(d, 32'h0, "unmapped data");
		chk(DW'(er), 32'h1, "unmapped error");
		wr(8'h44, 32'h9);
		rd_chk(ADDR_PAGE, 8'hc6, "page kept");
		$display("test page done");
	endtask

	// ****************************************
	// main
	// ****************************************
	initial begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end

	initial begin
		rst_b = 1'b0;
		clk_en = 1'b1;
		mode_load_strobe = 1'b0;
		mode_load_data = 8'h00;
		tx_start = 1'b0;
		evt = '0;
		record_latch_set = '0;
		port_counts = '0;
		repeat (3) @(posedge clk_sys);
		rst_b <= 1'b1;
		rd_chk(ADDR_CFG, CFG_RESET, "cfg reset");
		test_cfg();
		test_prio();
		test_poll();
		test_tx();
		test_stall();
		test_page();
		complete_run();
	end
endmodule
